/* File: rtl/ubg_pkg.sv */
package ubg_pkg;
	// ****************************************
	// Register map (indexed-set indices, then byte addresses)
	// ****************************************
	localparam logic [1:0] ICS_IDX_PRESCALE = 2'h1;
	localparam logic [1:0] ICS_IDX_SAMPLE = 2'h2;
	localparam logic [1:0] ICS_IDX_CLKSEL = 2'h3;
	localparam logic [5:0] ADDR_DIV_LOW = 6'h00;
	localparam logic [5:0] ADDR_DIV_HIGH = 6'h04;
	localparam logic [5:0] ADDR_PRESCALE = 6'h08;
	localparam logic [5:0] ADDR_SAMPLE = 6'h0C;
	localparam logic [5:0] ADDR_CLKSEL = 6'h10;
	localparam logic [5:0] ADDR_MODEM_CTL = 6'h14;
	localparam logic [5:0] ADDR_ENH_FEAT = 6'h18;
	localparam logic [5:0] ADDR_STATUS = 6'h1C;
	// ****************************************
	// Field positions and reset values
	// ****************************************
	localparam int MC_PRESCALE_EN_BIT = 7;
	localparam int EF_ENHANCED_BIT = 4;
	localparam int CS_TX_ISO_BIT = 7;
	localparam int CS_RX_ISO_BIT = 3;
	localparam int CS_DTR_TXCLK_BIT = 4;
	localparam int CS_DTR_NXCLK_BIT = 5;
	localparam logic [7:0] SAMPLE_RST = 8'h00;
	localparam logic [7:0] DIV_LOW_RST = 8'h01;
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic [7:0] PRESCALE_RST = 8'h08;
	localparam logic [4:0] SC_DEFAULT = 5'h10;
	localparam logic [3:0] SC_MIN_CODE = 4'h4;
	localparam logic [2:0] FRAC_STEPS = 3'h7;
	// ****************************************
	// Carriers
	// ****************************************
	typedef struct packed {
		logic [5:0] address;
		logic read;
		logic write;
		logic [31:0] writedata;
	} ubg_avl_req_t;
	typedef struct packed {
		logic [31:0] readdata;
		logic waitrequest;
	} ubg_avl_rsp_t;
	typedef struct packed {
		logic [15:0] divisor;
		logic [7:0] prescale;
		logic prescale_en;
		logic [3:0] sample_code;
	} ubg_cfg_t;
	typedef enum logic [1:0] {
		BUS_IDLE = 2'b00,
		BUS_ACK = 2'b01
	} ubg_bus_st_t;
	// Sample clocks per bit from the low code
	function automatic logic [4:0] ubg_sample_count(input logic [3:0] code);
		if (code < SC_MIN_CODE) begin
			return SC_DEFAULT;
		end
		return {1'b0, code};
	endfunction
endpackage

/* File: rtl/ubg_prescaler.sv */
`timescale 1ns/1ps
module ubg_prescaler
	import ubg_pkg::*;
(
	input wire logic MCLK_I, // Reference clock
	input wire logic SYS_RST_I, // Async reset
	input wire logic en_i, // Prescaler enabled
	input wire logic [7:0] ratio_i, // M:N
	output logic tick_o // Prescaled enable pulse
);
	typedef struct packed {
		logic [4:0] cnt;
		logic [3:0] acc;
		logic tick;
	} ubg_ps_t;
	ubg_ps_t s_q, s_d;
	logic [4:0] m;
	logic [2:0] n;
	logic [3:0] acc_sum;
	logic extra;
	logic [4:0] target;
	assign m = ratio_i[7:3];
	assign n = ratio_i[2:0];
	always_comb begin
		s_d = s_q;
		s_d.tick = 1'b0;
		// Distribute N stretched cycles over eight outputs
		acc_sum = s_q.acc + {1'b0, n};
		extra = acc_sum[3];
		// M of zero is treated as one
		target = ((m == 5'h00) ? 5'h01 : m) + {4'h0, extra} - 5'h01;
		if (!en_i) begin
			s_d.tick = 1'b1;
			s_d.cnt = 5'h00;
			s_d.acc = 4'h0;
		end else if (s_q.cnt >= target) begin
			s_d.tick = 1'b1;
			s_d.cnt = 5'h00;
			s_d.acc = {1'b0, acc_sum[2:0]};
		end else begin
			s_d.cnt = s_q.cnt + 5'h01;
		end
	end
	always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
	assign tick_o = en_i ? s_q.tick : 1'b1;
endmodule

/* File: rtl/ubg_divider.sv */
`timescale 1ns/1ps
module ubg_divider
	import ubg_pkg::*;
#(
	parameter int WIDTH = 16
) (
	input wire logic MCLK_I, // Reference clock
	input wire logic SYS_RST_I, // Async reset
	input wire logic step_i, // Advance enable
	input wire logic [WIDTH-1:0] limit_i, // Divide ratio
	output logic tick_o // One-cycle pulse
);
	typedef struct packed {
		logic [WIDTH-1:0] cnt;
		logic tick;
	} ubg_dv_t;
	ubg_dv_t s_q, s_d;
	logic [WIDTH-1:0] lim;
	always_comb begin
		s_d = s_q;
		s_d.tick = 1'b0;
		lim = (limit_i == '0) ? WIDTH'(1) : limit_i;
		if (step_i) begin
			if (s_q.cnt >= lim - WIDTH'(1)) begin
				s_d.cnt = '0;
				s_d.tick = 1'b1;
			end else begin
				s_d.cnt = s_q.cnt + WIDTH'(1);
			end
		end
	end
	always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
	assign tick_o = s_q.tick;
endmodule

/* File: rtl/ubg_baud_gen.sv */
// What this block does
// - Divide prescaled clock by 16-bit divisor, low byte plus 256 times high byte
// - Bit rate is clock over sample count times divisor times prescale
// - Prescaler divides by M plus N/8, M in bits 7:3, N in 2:0
// - Prescale ratio ranges 1.0 to 31.875 in eighth steps
// - Modem control bit 7 low bypasses prescaler, ratio exactly one
// - Reset bypasses prescaler and clears sample count register to zero
// - Sample codes 0-3 give 16 clocks per bit, 4-15 give 4-15
// - Upper four sample register bits do not affect sampling
// - Sample register reads back the last written value
// - Writes 0x01, 0x10, 0x11 give sixteen, never isochronous mode
// - Sample count register ignored in isochronous mode
// - Sample count applies with or without enhanced mode
// - Prescale at index 0x01, sample count at 0x02 of indexed set
// - External transmit clock on ring pin, receive clock on data-set-ready
// - Clock select bit 7 makes transmit 1x, bit 3 makes receive 1x
// - In 1x mode each bit follows one cycle of the 1x clock
// - Local 1x bit clock can drive the data-terminal-ready pin
// - Clock select at index 0x03, bits 4/5 put clocks on DTR pin
//
// Our own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module ubg_baud_gen
	import ubg_pkg::*;
(
	input wire logic MCLK_I, // 125 MHz reference clock
	input wire logic SYS_RST_I, // Async reset, active high
	input wire ubg_pkg::ubg_avl_req_t AVL_REQ_I, // Avalon request
	output ubg_pkg::ubg_avl_rsp_t AVL_RSP_O, // Avalon response
	input wire logic TX_EXT_CLOCK_PIN_I, // External tx 1x clock
	input wire logic RX_EXT_CLOCK_PIN_I, // External rx 1x clock
	input wire logic DTR_FUNC_I, // Normal DTR level from modem logic
	output logic DTR_PIN_O, // DTR pin level
	output logic SAMPLE_TICK_O, // Nx sample-clock pulse
	output logic TX_BIT_TICK_O, // Tx bit strobe
	output logic RX_BIT_TICK_O, // Rx bit strobe
	output logic TX_ISO_O, // Tx in 1x mode
	output logic RX_ISO_O // Rx in 1x mode
);
	import ubg_pkg::*;
	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		ubg_bus_st_t bus;
		logic [31:0] rdata;
		logic [7:0] div_low;
		logic [7:0] div_high;
		logic [7:0] prescale;
		logic [7:0] sample;
		logic [7:0] clksel;
		logic [7:0] modem_ctl;
		logic [7:0] enh_feat;
		logic [4:0] sc_cnt;
		logic tx_bit;
		logic rx_bit;
		logic nx_clk;
		logic tx1x_clk;
		logic [2:0] tx_sync;
		logic [2:0] rx_sync;
		logic dtr;
	} ubg_state_t;
	ubg_state_t s_q, s_d;
	logic pre_tick;
	logic div_tick;
	logic [15:0] divisor;
	logic [4:0] sc_num;
	logic tx_edge;
	logic rx_edge;
	logic wr_hit;
	assign divisor = {s_q.div_high, s_q.div_low};
	// ****************************************
	// Prescaler and divisor chain
	// ****************************************
	ubg_prescaler u_pre (
		.MCLK_I(MCLK_I),
		.SYS_RST_I(SYS_RST_I),
		.en_i(s_q.modem_ctl[MC_PRESCALE_EN_BIT]),
		.ratio_i(s_q.prescale),
		.tick_o(pre_tick)
	);
	ubg_divider #(
		.WIDTH(16)
	) u_div (
		.MCLK_I(MCLK_I),
		.SYS_RST_I(SYS_RST_I),
		.step_i(pre_tick),
		.limit_i(divisor),
		.tick_o(div_tick)
	);
	always_comb begin
		s_d = s_q;
		s_d.tx_bit = 1'b0;
		s_d.rx_bit = 1'b0;
		wr_hit = 1'b0;
		// Only low nibble steers sampling
		sc_num = ubg_sample_count(s_q.sample[3:0]);
		// ****************************************
		// External clock capture
		// ****************************************
		s_d.tx_sync = {s_q.tx_sync[1:0], TX_EXT_CLOCK_PIN_I};
		s_d.rx_sync = {s_q.rx_sync[1:0], RX_EXT_CLOCK_PIN_I};
		tx_edge = s_q.tx_sync[1] & ~s_q.tx_sync[2];
		rx_edge = s_q.rx_sync[1] & ~s_q.rx_sync[2];
		// ****************************************
		// Sample clock count to bit strobe
		// ****************************************
		if (div_tick) begin
			s_d.nx_clk = ~s_q.nx_clk;
			if (s_q.sc_cnt >= sc_num - 5'h01) begin
				s_d.sc_cnt = 5'h00;
				s_d.tx_bit = 1'b1;
				s_d.rx_bit = 1'b1;
				s_d.tx1x_clk = ~s_q.tx1x_clk;
			end else begin
				s_d.sc_cnt = s_q.sc_cnt + 5'h01;
			end
		end
		// 1x mode replaces the Nx strobe, counter ignored
		if (s_q.clksel[CS_TX_ISO_BIT]) begin
			s_d.tx_bit = tx_edge;
		end
		if (s_q.clksel[CS_RX_ISO_BIT]) begin
			s_d.rx_bit = rx_edge;
		end
		// ****************************************
		// DTR pin select
		// ****************************************
		if (s_q.clksel[CS_DTR_TXCLK_BIT]) begin
			s_d.dtr = s_q.clksel[CS_TX_ISO_BIT] ? s_q.tx_sync[1] : s_q.tx1x_clk;
		end else if (s_q.clksel[CS_DTR_NXCLK_BIT]) begin
			s_d.dtr = s_q.nx_clk;
		end else begin
			s_d.dtr = DTR_FUNC_I;
		end
		// ****************************************
		// Avalon slave, one wait state
		// ****************************************
		case (s_q.bus)
			BUS_IDLE: begin
				if (AVL_REQ_I.read || AVL_REQ_I.write) begin
					s_d.bus = BUS_ACK;
					wr_hit = AVL_REQ_I.write;
					s_d.rdata = 32'h0000_0000;
					case (AVL_REQ_I.address)
						ADDR_DIV_LOW: s_d.rdata[7:0] = s_q.div_low;
						ADDR_DIV_HIGH: s_d.rdata[7:0] = s_q.div_high;
						ADDR_PRESCALE: s_d.rdata[7:0] = s_q.prescale;
						ADDR_SAMPLE: s_d.rdata[7:0] = s_q.sample;
						ADDR_CLKSEL: s_d.rdata[7:0] = s_q.clksel;
						ADDR_MODEM_CTL: s_d.rdata[7:0] = s_q.modem_ctl;
						ADDR_ENH_FEAT: s_d.rdata[7:0] = s_q.enh_feat;
						ADDR_STATUS: s_d.rdata[4:0] = sc_num;
						default: s_d.rdata = 32'h0000_0000;
					endcase
				end
			end
			BUS_ACK: begin
				s_d.bus = BUS_IDLE;
			end
			default: begin
				s_d.bus = BUS_IDLE;
			end
		endcase
		if (wr_hit) begin
			case (AVL_REQ_I.address)
				ADDR_DIV_LOW: s_d.div_low = AVL_REQ_I.writedata[7:0];
				ADDR_DIV_HIGH: s_d.div_high = AVL_REQ_I.writedata[7:0];
				ADDR_PRESCALE: s_d.prescale = AVL_REQ_I.writedata[7:0];
				ADDR_SAMPLE: s_d.sample = AVL_REQ_I.writedata[7:0];
				ADDR_CLKSEL: s_d.clksel = AVL_REQ_I.writedata[7:0];
				ADDR_MODEM_CTL: begin
					s_d.modem_ctl[6:0] = AVL_REQ_I.writedata[6:0];
					// Prescaler enable writable only in enhanced mode
					if (s_q.enh_feat[EF_ENHANCED_BIT]) begin
						s_d.modem_ctl[MC_PRESCALE_EN_BIT] = AVL_REQ_I.writedata[MC_PRESCALE_EN_BIT];
					end
				end
				ADDR_ENH_FEAT: s_d.enh_feat = AVL_REQ_I.writedata[7:0];
				default: s_d.bus = BUS_ACK;
			endcase
		end
	end
	always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			s_q <= '0;
			s_q.bus <= BUS_IDLE;
			s_q.div_low <= DIV_LOW_RST;
			s_q.div_high <= BYTE_RST;
			s_q.prescale <= PRESCALE_RST;
			s_q.sample <= SAMPLE_RST;
			s_q.modem_ctl <= BYTE_RST;
		end else begin
			s_q <= s_d;
		end
	end
	// ****************************************
	// Outputs
	// ****************************************
	assign AVL_RSP_O.waitrequest = (AVL_REQ_I.read || AVL_REQ_I.write) && (s_q.bus != BUS_ACK);
	assign AVL_RSP_O.readdata = s_q.rdata;
	assign DTR_PIN_O = s_q.dtr;
	assign SAMPLE_TICK_O = div_tick;
	assign TX_BIT_TICK_O = s_q.tx_bit;
	assign RX_BIT_TICK_O = s_q.rx_bit;
	assign TX_ISO_O = s_q.clksel[CS_TX_ISO_BIT];
	assign RX_ISO_O = s_q.clksel[CS_RX_ISO_BIT];
endmodule

/* File: dv/ubg_clock_source.sv */
`timescale 1ns/1ps
module ubg_clock_source #(
	parameter int TX_HALF = 3,
	parameter int RX_HALF = 5
) (
	input wire logic clk_i, // Reference clock
	input wire logic run_i, // Clocks run while high
	output logic tx_clk_o, // Tx 1x clock, ring pin
	output logic rx_clk_o // Rx 1x clock, data-set-ready pin
);
	int tx_cnt = 0;
	int rx_cnt = 0;
	// Stands low between frames
	always @(posedge clk_i) begin
		tx_cnt <= run_i ? (tx_cnt + 1) % TX_HALF : 0;
		rx_cnt <= run_i ? (rx_cnt + 1) % RX_HALF : 0;
		if (!run_i) begin
			tx_clk_o <= 1'b0;
			rx_clk_o <= 1'b0;
		end else begin
			tx_clk_o <= (tx_cnt == TX_HALF - 1) ? !tx_clk_o : tx_clk_o;
			rx_clk_o <= (rx_cnt == RX_HALF - 1) ? !rx_clk_o : rx_clk_o;
		end
	end
endmodule

/* File: dv/ubg_baud_monitor.sv */
`timescale 1ns/1ps
module ubg_baud_monitor
	import ubg_pkg::*;
(
	input wire logic MCLK_I, // Clock
	input wire logic SYS_RST_I, // Reset
	input wire ubg_pkg::ubg_avl_req_t AVL_REQ_I, // Request
	input wire ubg_pkg::ubg_avl_rsp_t AVL_RSP_O, // Response
	input wire logic TX_EXT_CLOCK_PIN_I, // Tx pin
	input wire logic RX_EXT_CLOCK_PIN_I, // Rx pin
	input wire logic DTR_FUNC_I, // DTR level
	input wire logic DTR_PIN_O, // DTR pin
	input wire logic SAMPLE_TICK_O, // Sample tick
	input wire logic TX_BIT_TICK_O, // Tx tick
	input wire logic RX_BIT_TICK_O, // Rx tick
	input wire logic TX_ISO_O, // Tx 1x
	input wire logic RX_ISO_O // Rx 1x
);
	logic [7:0] cs_q;
	logic cs_wr;
	assign cs_wr = AVL_REQ_I.write && AVL_REQ_I.address == ADDR_CLKSEL;
	// Shadow of clock select
	always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			cs_q <= 8'h00;
		end else if (cs_wr && !AVL_RSP_O.waitrequest) begin
			cs_q <= AVL_REQ_I.writedata[7:0];
		end
	end
	default clocking @(posedge MCLK_I); endclocking
	default disable iff (SYS_RST_I);
	sequence s_cs_done;
		cs_wr && !AVL_RSP_O.waitrequest;
	endsequence
	sequence s_tx_edge;
		TX_ISO_O && $rose(TX_EXT_CLOCK_PIN_I);
	endsequence
	sequence s_rx_edge;
		RX_ISO_O && $rose(RX_EXT_CLOCK_PIN_I);
	endsequence
	AST_ONE_WAIT: assert property ((AVL_REQ_I.read || AVL_REQ_I.write) && AVL_RSP_O.waitrequest
		|=> !AVL_RSP_O.waitrequest) else $error("wait state count wrong");
	AST_READ_UPPER: assert property (AVL_REQ_I.read && !AVL_RSP_O.waitrequest
		|-> AVL_RSP_O.readdata[31:8] == 24'h0) else $error("upper read bits set");
	AST_TX_ISO_TICK: assert property (s_tx_edge |-> ##[2:4] TX_BIT_TICK_O)
		else $error("tx 1x tick missing");
	AST_RX_ISO_TICK: assert property (s_rx_edge |-> ##[2:4] RX_BIT_TICK_O)
		else $error("rx 1x tick missing");
	AST_SAMPLE_BIT: assert property (TX_BIT_TICK_O && !TX_ISO_O && !$past(TX_ISO_O)
		|-> $past(SAMPLE_TICK_O)) else $error("bit tick without sample tick");
	AST_DTR_FUNC: assert property (cs_q[5:4] == 2'b00 && !cs_wr
		|=> DTR_PIN_O == $past(DTR_FUNC_I)) else $error("dtr not passed through");
	AST_TX_ISO_FLAG: assert property (s_cs_done |=> ##1 TX_ISO_O == cs_q[CS_TX_ISO_BIT])
		else $error("tx 1x flag wrong");
	AST_RX_ISO_FLAG: assert property (s_cs_done |=> ##1 RX_ISO_O == cs_q[CS_RX_ISO_BIT])
		else $error("rx 1x flag wrong");
endmodule
bind ubg_baud_gen ubg_baud_monitor mon (.MCLK_I, .SYS_RST_I, .AVL_REQ_I, .AVL_RSP_O, .TX_EXT_CLOCK_PIN_I,
	.RX_EXT_CLOCK_PIN_I, .DTR_FUNC_I, .DTR_PIN_O, .SAMPLE_TICK_O, .TX_BIT_TICK_O, .RX_BIT_TICK_O, .TX_ISO_O,
	.RX_ISO_O);

/* File: dv/test_ubg_baud_gen.sv */
`timescale 1ns/1ps
module test_ubg_baud_gen;
	import ubg_pkg::*;
	logic MCLK_I = 1'b0;
	logic SYS_RST_I = 1'b1;
	ubg_avl_req_t req = '0;
	ubg_avl_rsp_t rsp;
	logic run = 1'b0;
	logic dtr_func = 1'b0;
	logic tx_ck, rx_ck, dtr, tx_iso, rx_iso;
	logic [3:0] ticks;
	logic dtr_q = 1'b0;
	logic [31:0] rd;
	int bad_count = 0;
	int comparisons = 0;
	int cyc;
	logic [13:0] rst_rows[9] = '{14'h0001, 14'h0400, 14'h0808, 14'h0C00, 14'h1000, 14'h1400, 14'h1800,
		14'h1C10, 14'h2000};
	logic [15:0] sc_rows[8] = '{16'h0010, 16'h0110, 16'h0310, 16'h1010, 16'h1110, 16'h0404, 16'h0F0F,
		16'hF505};
	logic [7:0] cp_vals[3] = '{8'h09, 8'h0B, 8'hFF};
	always #4 MCLK_I = ~MCLK_I;
	ubg_baud_gen dut (.MCLK_I, .SYS_RST_I, .AVL_REQ_I(req), .AVL_RSP_O(rsp), .TX_EXT_CLOCK_PIN_I(tx_ck),
		.RX_EXT_CLOCK_PIN_I(rx_ck), .DTR_FUNC_I(dtr_func), .DTR_PIN_O(dtr), .SAMPLE_TICK_O(ticks[0]),
		.TX_BIT_TICK_O(ticks[1]), .RX_BIT_TICK_O(ticks[2]), .TX_ISO_O(tx_iso), .RX_ISO_O(rx_iso));
	ubg_clock_source src (.clk_i(MCLK_I), .run_i(run), .tx_clk_o(tx_ck), .rx_clk_o(rx_ck));
	// Rising edge of the DTR pin as a one-cycle pulse
	always @(posedge MCLK_I) begin
		dtr_q <= dtr;
	end
	assign ticks[3] = dtr & ~dtr_q;
	task automatic report_and_stop();
		if (bad_count == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected %s: expected %h, seen %h", nm, exp, seen);
		end
	endtask
	task automatic bus(input logic we, input logic [5:0] a, input logic [7:0] d);
		int i;
		@(posedge MCLK_I);
		req <= '{a, !we, we, {24'h0, d}};
		for (i = 0; i < 50; i++) begin
			@(posedge MCLK_I);
			if (rsp.waitrequest === 1'b0) begin
				rd = rsp.readdata;
				break;
			end
		end
		req <= '0;
		if (i == 50) begin
			bad_count++;
			report_and_stop();
		end
	endtask
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rdchk(input string nm, input logic [5:0] a, input logic [31:0] exp);
		bus(1'b0, a, 8'h00);
		check(nm, rd, exp);
	endtask
	// Cycles over n periods, first pulse dropped
	task automatic meas(input logic [1:0] sel, input int n);
		int i;
		int k;
		k = 0;
		cyc = 0;
		for (i = 0; i < 4000 && k < n + 2; i++) begin
			@(negedge MCLK_I);
			if (k > 1) cyc++;
			if (ticks[sel] === 1'b1) k++;
		end
		if (k < n + 2) begin
			bad_count++;
			report_and_stop();
		end
	endtask
	initial begin
		repeat (6) @(posedge MCLK_I);
		SYS_RST_I <= 1'b0;
		foreach (rst_rows[i]) begin
			rdchk("reset", rst_rows[i][13:8], {24'h0, rst_rows[i][7:0]});
		end
		foreach (sc_rows[i]) begin
			wr(ADDR_SAMPLE, sc_rows[i][15:8]);
			rdchk("sample", ADDR_SAMPLE, {24'h0, sc_rows[i][15:8]});
			rdchk("clocks", ADDR_STATUS, {24'h0, sc_rows[i][7:0]});
		end
		wr(6'h24, 8'hA5);
		rdchk("unmapped", 6'h24, 32'h0);
		wr(ADDR_SAMPLE, 8'h04);
		wr(ADDR_PRESCALE, 8'h0B);
		wr(ADDR_DIV_HIGH, 8'h01);
		wr(ADDR_DIV_LOW, 8'h02);
		meas(2'd0, 1);
		check("divisor", cyc, 258);
		wr(ADDR_DIV_HIGH, 8'h00);
		wr(ADDR_DIV_LOW, 8'h03);
		wr(ADDR_MODEM_CTL, 8'h80);
		rdchk("modem", ADDR_MODEM_CTL, 32'h0);
		meas(2'd0, 8);
		check("bypass", cyc, 24);
		meas(2'd1, 2);
		check("bit", cyc, 24);
		wr(ADDR_ENH_FEAT, 8'h10);
		wr(ADDR_MODEM_CTL, 8'h80);
		meas(2'd0, 8);
		check("fraction", cyc, 33);
		wr(ADDR_DIV_LOW, 8'h01);
		foreach (cp_vals[i]) begin
			wr(ADDR_PRESCALE, cp_vals[i]);
			meas(2'd0, 8);
			check("ratio", cyc, {24'h0, cp_vals[i]});
		end
		wr(ADDR_ENH_FEAT, 8'h00);
		wr(ADDR_SAMPLE, 8'h06);
		rdchk("clocks", ADDR_STATUS, 32'h6);
		wr(ADDR_PRESCALE, 8'h08);
		wr(ADDR_DIV_LOW, 8'h05);
		wr(ADDR_CLKSEL, 8'h20);
		meas(2'd3, 1);
		check("dtr nx", cyc, 10);
		wr(ADDR_CLKSEL, 8'h10);
		meas(2'd3, 1);
		check("dtr tx", cyc, 60);
		run <= 1'b1;
		wr(ADDR_CLKSEL, 8'h88);
		rdchk("clksel", ADDR_CLKSEL, 32'h88);
		check("iso", {tx_iso, rx_iso}, 2'b11);
		meas(2'd1, 2);
		check("tx 1x", cyc, 12);
		meas(2'd2, 2);
		check("rx 1x", cyc, 20);
		@(posedge MCLK_I);
		dtr_func <= 1'b1;
		repeat (3) @(negedge MCLK_I);
		check("dtr", dtr, 1'b1);
		@(posedge MCLK_I);
		dtr_func <= 1'b0;
		repeat (3) @(negedge MCLK_I);
		check("dtr", dtr, 1'b0);
		wr(ADDR_CLKSEL, 8'h98);
		meas(2'd3, 1);
		check("dtr 1x", cyc, 6);
		@(posedge MCLK_I);
		run <= 1'b0;
		SYS_RST_I <= 1'b1;
		repeat (2) @(posedge MCLK_I);
		SYS_RST_I <= 1'b0;
		rdchk("reset", ADDR_SAMPLE, 32'h0);
		rdchk("reset", ADDR_MODEM_CTL, 32'h0);
		report_and_stop();
	end
endmodule
